// ==== pkg/host_port_consts.svh ====
/*
  timing and layout constants shared by both ends of the sram-like host port.
  assumes it is included by its bare name.
*/
`ifndef HOST_PORT_CONSTS_SVH
`define HOST_PORT_CONSTS_SVH
`define HP_DATA_W 32
`define HP_ADDR_W 8
`define HP_CLK_NS 8
`define HP_STROBE_NS 40
`define HP_STROBE_CYC ((`HP_STROBE_NS + `HP_CLK_NS - 1) / `HP_CLK_NS)
`endif

// ==== pkg/host_port_pkg.sv ====
/*
  types of the host port: state encodings of both ends.
  assumes host_port_consts.svh is on the include path.
*/
`include "host_port_consts.svh"
package host_port_pkg;
  typedef enum logic [1:0] {
    DEV_IDLE = 2'b00,
    DEV_ACT = 2'b01,
    DEV_WAIT = 2'b10
  } dev_state_t;
  typedef enum logic [1:0] {
    HOST_IDLE = 2'b00,
    HOST_STROBE = 2'b01,
    HOST_GAP = 2'b10
  } host_state_t;
endpackage

// ==== pkg/host_port_if.sv ====
/*
  pin level of the host port between cpu end and device end.
  assumes the testbench resolves the data wire from the two enables.
*/
`timescale 1ns/1ns
interface host_port_if;
  logic [31:0] data_from_host;
  logic data_from_host_oe;
  logic [31:0] data_from_dev;
  logic data_from_dev_oe;
  logic [31:0] data_in;
  logic [7:0] addr;
  logic read_strobe_low;
  logic write_strobe_low;
  logic chip_select_low;
  logic fifo_sel;
  logic end_sel;
  modport dev (
    input data_in, addr, read_strobe_low, write_strobe_low, chip_select_low,
    input fifo_sel, end_sel,
    output data_from_dev, data_from_dev_oe
  );
  modport host (
    input data_in,
    output data_from_host, data_from_host_oe, addr, read_strobe_low,
    output write_strobe_low, chip_select_low, fifo_sel, end_sel
  );
endinterface

// ==== rtl/host_port_dev.sv ====
/*
  device end of the sram-like host port: synchronises the strobes, decodes
  register or fifo accesses, swaps bytes for big endian and drives read data.
  assumes the host holds address and write data stable across the strobe.
*/
`timescale 1ns/1ns
`include "host_port_consts.svh"
// Functional notes
// R01: 32-bit two-way data bus
// R02: word address bits 9..2 only select
// R03: read strobe valid only with chip select
// R04: write data taken only with chip select
// R05: strobes ignored while chip select high
// R06: direct mode: reads rx fifo, writes tx fifo
// R07: direct mode ignores address lines
// R08: end select high means big endian
// R09: endianness may change between accesses
// R10: drive bus only during selected read
// R11: synchronise strobes before side effects
module host_port_dev
  import host_port_pkg::*;
#(
  parameter int DATA_W = `HP_DATA_W,
  parameter int ADDR_W = `HP_ADDR_W
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // pins
  host_port_if.dev pins,
  // internal side
  output logic reg_wr,
  output logic reg_rd,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  output logic tx_fifo_wr,
  output logic [DATA_W-1:0] tx_fifo_data,
  output logic rx_fifo_rd,
  input wire logic [DATA_W-1:0] rx_fifo_data
);
  localparam int BYTES = DATA_W / 8;

  typedef struct packed {
    logic rd_s1;
    logic rd_s2;
    logic wr_s1;
    logic wr_s2;
    dev_state_t st;
    // byte order latched once per access
    logic big;
    logic reg_wr;
    logic reg_rd;
    logic tx_wr;
    logic rx_rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
  } dev_regs_t;

  dev_regs_t s_q;
  dev_regs_t s_d;
  logic rd_sel;
  logic wr_sel;

  function automatic logic [DATA_W-1:0] swap(input logic [DATA_W-1:0] v, input logic big);
    logic [DATA_W-1:0] r;
    r = v;
    if (big) begin
      for (int i = 0; i < BYTES; i++) begin
        r[i*8 +: 8] = v[(BYTES-1-i)*8 +: 8];
      end
    end
    return r;
  endfunction

  // one-hot target {rx fifo read, reg read, tx fifo write, reg write}
  function automatic logic [3:0] pick(input logic fifo, input logic wr);
    logic [3:0] t;
    if (wr) begin
      t = fifo ? 4'h2 : 4'h1;
    end else begin
      t = fifo ? 4'h8 : 4'h4;
    end
    return t;
  endfunction

  // a strobe counts only while chip select is low as well
  function automatic logic qualified(input logic strobe_low, input logic sel_low);
    return ~strobe_low & ~sel_low;
  endfunction

  // second stage of each pair: synchronised select qualified strobes
  assign rd_sel = s_q.rd_s2; // R03 R05 R11
  assign wr_sel = s_q.wr_s2; // R04 R05 R11

  always_comb begin
    s_d = s_q;
    s_d.reg_wr = 1'b0;
    s_d.reg_rd = 1'b0;
    s_d.tx_wr = 1'b0;
    s_d.rx_rd = 1'b0;
    // raw strobe pins go only into the first stage and the bus enable
    s_d.rd_s1 = qualified(pins.read_strobe_low, pins.chip_select_low); // R03 R05
    s_d.wr_s1 = qualified(pins.write_strobe_low, pins.chip_select_low); // R04 R05
    s_d.rd_s2 = s_q.rd_s1; // R11
    s_d.wr_s2 = s_q.wr_s1; // R11
    case (s_q.st)
      DEV_IDLE: begin
        if (rd_sel) begin
          s_d.st = DEV_ACT;
          s_d.big = pins.end_sel; // R09
          // direct mode never looks at the address
          {s_d.rx_rd, s_d.reg_rd, s_d.tx_wr, s_d.reg_wr} = pick(pins.fifo_sel, 1'b0); // R06 R07
          if (!pins.fifo_sel) begin
            s_d.addr = pins.addr; // R02
          end
        end else if (wr_sel) begin
          s_d.st = DEV_ACT;
          // sample endianness per access so it may change between cycles
          s_d.big = pins.end_sel; // R09
          s_d.wdata = swap(pins.data_in, pins.end_sel); // R01 R08
          {s_d.rx_rd, s_d.reg_rd, s_d.tx_wr, s_d.reg_wr} = pick(pins.fifo_sel, 1'b1); // R06 R07
          if (!pins.fifo_sel) begin
            s_d.addr = pins.addr; // R02
          end
        end
      end
      DEV_ACT: begin
        // read data returns the cycle after the internal read pulse
        s_d.st = DEV_WAIT;
        // a write leaves the read word alone so the bus only moves on reads
        if (s_q.rx_rd) begin
          s_d.rdata = swap(rx_fifo_data, s_q.big); // R06 R08
        end else if (s_q.reg_rd) begin
          s_d.rdata = swap(reg_rdata, s_q.big); // R08
        end
      end
      DEV_WAIT: begin
        // one access per strobe: wait for the strobe to go away
        if (!rd_sel && !wr_sel) begin
          s_d.st = DEV_IDLE;
        end
      end
      default: begin
        s_d.st = DEV_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_wr = s_q.reg_wr;
  assign reg_rd = s_q.reg_rd;
  assign reg_addr = s_q.addr;
  assign reg_wdata = s_q.wdata;
  assign tx_fifo_wr = s_q.tx_wr;
  assign tx_fifo_data = s_q.wdata;
  assign rx_fifo_rd = s_q.rx_rd;
  assign pins.data_from_dev = s_q.rdata; // R01
  // enable follows the pins directly so the bus floats as soon as the cpu lets go
  assign pins.data_from_dev_oe = ~pins.chip_select_low & ~pins.read_strobe_low; // R10
endmodule // host_port_dev

// ==== rtl/host_port_host.sv ====
/*
  cpu end of the sram-like host port: turns one request into a strobe of
  fixed length with address, data and mode pins held across it.
  assumes the device end has read data on the wire before the strobe ends.
*/
`timescale 1ns/1ns
`include "host_port_consts.svh"
module host_port_host
  import host_port_pkg::*;
#(
  parameter int DATA_W = `HP_DATA_W,
  parameter int ADDR_W = `HP_ADDR_W,
  parameter int STROBE_CYC = `HP_STROBE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // pins
  host_port_if.host pins,
  // user request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_fifo,
  input wire logic req_big_endian,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  output logic req_ready,
  // answer
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata
);
  typedef struct packed {
    host_state_t st;
    logic [7:0] cnt;
    logic wr;
    logic fifo;
    logic big;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic rsp;
    logic [DATA_W-1:0] rdata;
  } host_regs_t;

  host_regs_t s_q;
  host_regs_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.rsp = 1'b0;
    case (s_q.st)
      HOST_IDLE: begin
        if (req_valid) begin
          s_d.st = HOST_STROBE;
          s_d.cnt = 8'(STROBE_CYC);
          s_d.wr = req_write;
          s_d.fifo = req_fifo;
          s_d.big = req_big_endian;
          s_d.addr = req_addr;
          s_d.wdata = req_wdata;
        end
      end
      HOST_STROBE: begin
        s_d.cnt = s_q.cnt - 8'h01;
        if (s_q.cnt == 8'h01) begin
          s_d.st = HOST_GAP;
          s_d.rsp = ~s_q.wr;
          s_d.rdata = pins.data_in; // R01
        end
      end
      HOST_GAP: begin
        // idle gap lets the device see the strobe released
        s_d.st = HOST_IDLE;
      end
      default: begin
        s_d.st = HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign req_ready = (s_q.st == HOST_IDLE);
  assign rsp_valid = s_q.rsp;
  assign rsp_rdata = s_q.rdata;
  assign pins.chip_select_low = ~(s_q.st == HOST_STROBE); // R05
  assign pins.read_strobe_low = ~((s_q.st == HOST_STROBE) & ~s_q.wr); // R03
  assign pins.write_strobe_low = ~((s_q.st == HOST_STROBE) & s_q.wr); // R04
  assign pins.addr = s_q.addr; // R02
  assign pins.fifo_sel = s_q.fifo;
  assign pins.end_sel = s_q.big;
  assign pins.data_from_host = s_q.wdata;
  assign pins.data_from_host_oe = (s_q.st == HOST_STROBE) & s_q.wr; // R01
endmodule // host_port_host

// ==== tb/host_port_assertions.sv ====
/*
  wire checks of the host port between the two ends.
  assumes one mclk domain with resetn asynchronous, active low.
*/
`timescale 1ns/1ns
module host_port_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // pins
  input wire logic [31:0] data_from_host,
  input wire logic data_from_host_oe,
  input wire logic [31:0] data_from_dev,
  input wire logic data_from_dev_oe,
  input wire logic [7:0] addr,
  input wire logic read_strobe_low,
  input wire logic write_strobe_low,
  input wire logic chip_select_low,
  input wire logic fifo_sel,
  input wire logic end_sel
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  sequence s_sel_held;
    !chip_select_low [*4];
  endsequence
  sequence s_in_access;
    !chip_select_low && $past(!chip_select_low);
  endsequence
  property p_rd_drive;
    data_from_dev_oe == (!chip_select_low && !read_strobe_low);
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("device bus drive outside a selected read");
  property p_one_driver;
    !(data_from_dev_oe && data_from_host_oe);
  endproperty
  a_one_driver: assert property (p_one_driver)
    else $error("both ends drive the data bus");
  property p_rd_qual;
    !read_strobe_low |-> !chip_select_low;
  endproperty
  a_rd_qual: assert property (p_rd_qual)
    else $error("read strobe low without chip select");
  property p_wr_qual;
    !write_strobe_low |-> !chip_select_low;
  endproperty
  a_wr_qual: assert property (p_wr_qual)
    else $error("write strobe low without chip select");
  property p_one_strobe;
    !chip_select_low |-> (read_strobe_low != write_strobe_low);
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("selected cycle without exactly one strobe");
  property p_sel_len;
    $fell(chip_select_low) |-> s_sel_held;
  endproperty
  a_sel_len: assert property (p_sel_len)
    else $error("strobe too short to be synchronised");
  property p_addr_hold;
    s_in_access |-> $stable(addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved inside an access");
  property p_mode_hold;
    s_in_access |-> $stable(end_sel) && $stable(fifo_sel);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("mode pins moved inside an access");
  property p_dev_upd;
    $changed(data_from_dev) |-> $past(!chip_select_low && !read_strobe_low);
  endproperty
  a_dev_upd: assert property (p_dev_upd)
    else $error("read data changed outside a read");
endmodule // host_port_checker

// ==== tb/test_sram_like_host_bus_port.sv ====
/*
  testbench: cpu end and device end joined by the pin interface.
  assumes 125 MHz mclk; user side is driven at the falling edge.
*/
`timescale 1ns/1ns
module test_sram_like_host_bus_port;
  import host_port_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0, req_write = 1'b0, req_fifo = 1'b0, req_big_endian = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [31:0] req_wdata = 32'h0;
  logic req_ready, rsp_valid, reg_wr, reg_rd, tx_fifo_wr, rx_fifo_rd;
  logic [7:0] reg_addr, madr;
  logic [31:0] rsp_rdata, reg_wdata, tx_fifo_data, mdat, rdat;
  logic [31:0] reg_rdata = 32'hC0DE_0001;
  logic [31:0] rx_fifo_data = 32'hF1F0_0002;
  logic [3:0] kind;
  int bad_count = 0, cmp_count = 0, n_act = 0, n_rsp = 0;
  always #4 mclk = ~mclk;
  host_port_if pif ();
  // a released wire toggles so a stale value cannot pass
  assign pif.data_in = pif.data_from_dev_oe ? pif.data_from_dev :
    pif.data_from_host_oe ? pif.data_from_host : {16{mclk, ~mclk}};
  host_port_host host_port_host_i (.mclk, .resetn, .pins(pif.host), .req_valid, .req_write,
    .req_fifo, .req_big_endian, .req_addr, .req_wdata, .req_ready, .rsp_valid, .rsp_rdata);
  host_port_dev host_port_dev_i (.mclk, .resetn, .pins(pif.dev), .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata, .reg_rdata, .tx_fifo_wr, .tx_fifo_data, .rx_fifo_rd, .rx_fifo_data);
  host_port_checker host_port_checker_i (.mclk, .resetn, .data_from_host(pif.data_from_host),
    .data_from_host_oe(pif.data_from_host_oe), .data_from_dev(pif.data_from_dev),
    .data_from_dev_oe(pif.data_from_dev_oe), .addr(pif.addr), .end_sel(pif.end_sel),
    .read_strobe_low(pif.read_strobe_low), .write_strobe_low(pif.write_strobe_low),
    .chip_select_low(pif.chip_select_low), .fifo_sel(pif.fifo_sel));
  always @(posedge mclk) begin
    if (reg_wr | tx_fifo_wr | reg_rd | rx_fifo_rd) begin
      n_act <= n_act + 1;
      kind <= {rx_fifo_rd, reg_rd, tx_fifo_wr, reg_wr};
      mdat <= tx_fifo_wr ? tx_fifo_data : reg_wdata;
      madr <= reg_addr;
    end
    if (rsp_valid) begin
      n_rsp <= n_rsp + 1;
      rdat <= rsp_rdata;
    end
  end
  function automatic logic [31:0] sw(input logic b, input logic [31:0] d);
    return b ? {d[7:0], d[15:8], d[23:16], d[31:24]} : d;
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, f, b, input logic [7:0] a, input logic [31:0] d);
    int n0, r0, t;
    n0 = n_act;
    r0 = n_rsp;
    @(negedge mclk);
    {req_valid, req_write, req_fifo, req_big_endian, req_addr, req_wdata} = {1'b1, w, f, b, a, d};
    for (t = 0; req_ready !== 1'b1 && t < 20; t++) @(negedge mclk);
    if (t >= 20) begin
      bad_count++;
      print_verdict();
    end
    @(negedge mclk);
    req_valid = 1'b0;
    for (t = 0; (n_act == n0 || (!w && n_rsp == r0)) && t < 40; t++) @(negedge mclk);
    if (t >= 40) begin
      bad_count++;
      print_verdict();
    end
    chk("kind", 32'(kind), 32'h1 << {!w, f});
    if (!f) chk("addr", 32'(madr), 32'(a));
    chk("data", w ? mdat : rdat, sw(b, w ? d : (f ? rx_fifo_data : reg_rdata)));
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    resetn = 1'b1;
    // every kind and endianness, endianness flipping between accesses
    for (int i = 0; i < 16; i++) begin
      acc(i[0], i[1], i[2] ^ i[3], 8'h01 << i[2:0], 32'h1234_5678 + i);
    end
    chk("oe", 32'(pif.data_from_dev_oe), 32'h0);
    print_verdict();
  end
endmodule // test_sram_like_host_bus_port
